// ### src/jcp_top.sv
`timescale 1ns/1ns
module jcp_top
  import jcp_pkg::*;
#(
  parameter int DW = jcp_pkg::DATA_W
) (
  input  wire logic          i_mclk,
  input  wire logic          i_srst,
  input  wire logic          i_tck,
  input  wire logic          i_tms,
  input  wire logic          i_tdi,
  output logic               o_tdo,
  output logic               o_tdo_oe,
  input  wire logic [1:0]    i_config_scheme_select,
  input  wire logic          i_passive_load_active,
  output logic               o_passive_abort,
  input  wire logic          i_active_clock_req,
  output logic               o_config_clock_out,
  output logic               o_user_io_hiz,
  output logic               o_cfg_active,
  output logic               o_cfg_valid,
  input  wire logic          i_cfg_ready,
  output logic [DW-1:0]      o_cfg_data,
  output logic               o_stall
);
  import jcp_pkg::*;
  // all checks run on the system clock and sleep through reset
  default clocking mclk_cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);
  // elaboration guard on the word width
  if (DW < 1 || DW > 32) begin : g_bad_dw
    $error("data width out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and test clock edge detection
  logic [1:0] tck_s_ff, tms_s_ff, tdi_s_ff;
  logic       tck_d_ff;
  always_ff @(posedge i_mclk) begin
    tck_s_ff <= {tck_s_ff[0], i_tck};
    tms_s_ff <= {tms_s_ff[0], i_tms};
    tdi_s_ff <= {tdi_s_ff[0], i_tdi};
    tck_d_ff <= tck_s_ff[1];
  end
  wire tck_rise = tck_s_ff[1] && !tck_d_ff;
  wire tck_fall = !tck_s_ff[1] && tck_d_ff;
  wire tms      = tms_s_ff[1];
  wire tdi      = tdi_s_ff[1];
  // strapped scheme pins are static but still come from outside
  logic [1:0] sel_s1_ff, sel_s2_ff;
  always_ff @(posedge i_mclk) begin
    sel_s1_ff <= i_config_scheme_select;
    sel_s2_ff <= sel_s1_ff;
  end
  wire [1:0] scheme_sel = sel_s2_ff;

  //////////////////////////////////////////////////////////////////////
  // tap state machine
  jcp_state_e st_ff, nxt_st;
  always_comb begin
    case (st_ff)
      JCP_TLR:    nxt_st = tms ? JCP_TLR    : JCP_RTI;
      JCP_RTI:    nxt_st = tms ? JCP_SEL_DR : JCP_RTI;
      JCP_SEL_DR: nxt_st = tms ? JCP_SEL_IR : JCP_CAP_DR;
      JCP_CAP_DR: nxt_st = tms ? JCP_EX1_DR : JCP_SH_DR;
      JCP_SH_DR:  nxt_st = tms ? JCP_EX1_DR : JCP_SH_DR;
      JCP_EX1_DR: nxt_st = tms ? JCP_UPD_DR : JCP_PA_DR;
      JCP_PA_DR:  nxt_st = tms ? JCP_EX2_DR : JCP_PA_DR;
      JCP_EX2_DR: nxt_st = tms ? JCP_UPD_DR : JCP_SH_DR;
      JCP_UPD_DR: nxt_st = tms ? JCP_SEL_DR : JCP_RTI;
      JCP_SEL_IR: nxt_st = tms ? JCP_TLR    : JCP_CAP_IR;
      JCP_CAP_IR: nxt_st = tms ? JCP_EX1_IR : JCP_SH_IR;
      JCP_SH_IR:  nxt_st = tms ? JCP_EX1_IR : JCP_SH_IR;
      JCP_EX1_IR: nxt_st = tms ? JCP_UPD_IR : JCP_PA_IR;
      JCP_PA_IR:  nxt_st = tms ? JCP_EX2_IR : JCP_PA_IR;
      JCP_EX2_IR: nxt_st = tms ? JCP_UPD_IR : JCP_SH_IR;
      JCP_UPD_IR: nxt_st = tms ? JCP_SEL_DR : JCP_RTI;
      default:    nxt_st = JCP_TLR;
    endcase
  end
  // advance only on a rising test clock edge
  always_ff @(posedge i_mclk) begin
    if (i_srst) st_ff <= JCP_TLR;
    else if (tck_rise) st_ff <= nxt_st; // RQ7 RQ10
  end

  //////////////////////////////////////////////////////////////////////
  // instruction register
  logic [IR_W-1:0] ir_sh_ff, ir_ff;
  always_ff @(posedge i_mclk) begin
    if (i_srst || st_ff == JCP_TLR) begin
      ir_sh_ff <= '0;
      ir_ff    <= IR_RESET; // RQ10
    end else if (tck_rise) begin
      case (st_ff)
        JCP_CAP_IR: ir_sh_ff <= IR_CAPTURE;
        JCP_SH_IR:  ir_sh_ff <= {tdi, ir_sh_ff[IR_W-1:1]}; // RQ4
        JCP_UPD_IR: ir_ff    <= ir_sh_ff;
        default:    ir_sh_ff <= ir_sh_ff;
      endcase
    end
  end
  wire cfg_sel = ir_ff == IR_CONFIG;

  //////////////////////////////////////////////////////////////////////
  // data registers: bypass bit and configuration word shifter
  logic          byp_ff;
  logic [DW-1:0] dr_ff;
  logic [$clog2(DW+1)-1:0] cnt_ff;
  logic          push_ff;
  logic          fifo_ready;
  wire           word_done = cnt_ff == ($clog2(DW+1))'(DW - 1);
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      byp_ff  <= 1'b0;
      dr_ff   <= '0;
      cnt_ff  <= '0;
      push_ff <= 1'b0;
    end else begin
      push_ff <= 1'b0;
      if (tck_rise && st_ff == JCP_CAP_DR) begin
        byp_ff <= 1'b0;
        cnt_ff <= '0;
      end else if (tck_rise && st_ff == JCP_SH_DR) begin
        byp_ff <= tdi; // RQ4
        dr_ff  <= {tdi, dr_ff[DW-1:1]};
        if (cfg_sel) begin
          // a full word goes to the fifo; lsb first on the wire
          cnt_ff  <= word_done ? '0 : cnt_ff + 1'b1;
          push_ff <= word_done;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // configuration data buffer toward the array loader
  logic [DW-1:0] push_data_ff;
  always_ff @(posedge i_mclk) begin
    if (i_srst) push_data_ff <= '0;
    else if (tck_rise && st_ff == JCP_SH_DR)
      push_data_ff <= {tdi, dr_ff[DW-1:1]};
  end
  // buffer is emptied whenever the tap sits in reset
  wire tap_rst = st_ff == JCP_TLR;
  // loader stall is exported: the host must slow the test clock
  assign o_stall = !fifo_ready;
  jcp_fifo #(
    .WIDTH (DW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_srst      (i_srst),
    .i_flush     (tap_rst),
    .i_in_valid  (push_ff),
    .o_in_ready  (fifo_ready),
    .i_in_data   (push_data_ff),
    .o_out_valid (o_cfg_valid),
    .i_out_ready (i_cfg_ready),
    .o_out_data  (o_cfg_data)
  );

  //////////////////////////////////////////////////////////////////////
  // configuration session: priority, abort, clock gating, pin release
  logic cfg_ff;
  wire  cfg_go = cfg_sel && st_ff != JCP_TLR;
  always_ff @(posedge i_mclk) begin
    if (i_srst || st_ff == JCP_TLR) cfg_ff <= 1'b0;
    else if (cfg_sel) cfg_ff <= 1'b1; // RQ1 starts without waiting
  end
  assign o_cfg_active  = cfg_ff;
  assign o_user_io_hiz = cfg_ff; // RQ9
  // passive load is dropped while boundary-scan configuration runs
  assign o_passive_abort = cfg_ff && i_passive_load_active
                           && scheme_sel == SEL_PASSIVE; // RQ2

  // active serial clock divider; stopped from the very edge a load
  // starts, so no pulse slips out while the session flag rises
  logic [3:0] div_ff;
  logic       cclk_ff;
  wire        active_run = i_active_clock_req && !cfg_ff && !cfg_go
                           && scheme_sel == SEL_ACTIVE;
  always_ff @(posedge i_mclk) begin
    if (i_srst || !active_run) begin
      div_ff  <= '0;
      cclk_ff <= 1'b0; // RQ3
    end else if (div_ff == 4'(CCLK_DIV - 1)) begin
      div_ff  <= '0;
      cclk_ff <= !cclk_ff;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end
  assign o_config_clock_out = cclk_ff;

  //////////////////////////////////////////////////////////////////////
  // test data out, retimed on the falling test clock edge
  wire shifting = st_ff == JCP_SH_DR || st_ff == JCP_SH_IR;
  wire tdo_bit  = st_ff == JCP_SH_IR ? ir_sh_ff[0]
                : (ir_ff == IR_BYPASS ? byp_ff : dr_ff[0]);
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_tdo    <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo    <= tdo_bit;   // RQ5
      o_tdo_oe <= shifting;  // RQ6
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  chk_oe_shift: assert property ($rose(o_tdo_oe) // RQ6
    |-> $past(tck_fall) && $past(shifting))
    else $error("tdo enabled outside shift");
  chk_tdo_fall: assert property ($changed(o_tdo) |-> $past(tck_fall)) // RQ5
    else $error("tdo changed off falling edge");
  chk_state_rise: assert property ($changed(st_ff) // RQ7
    |-> $past(tck_rise))
    else $error("state moved off rising edge");
  chk_tms_reset: assert property (st_ff == JCP_SEL_IR && tms // RQ10
    && tck_rise |=> st_ff == JCP_TLR)
    else $error("select-ir with tms did not reset");
  // pins may only be handed back once the tap has gone to reset
  chk_io_hiz: assert property ($fell(o_user_io_hiz) // RQ9
    |-> $past(st_ff) == JCP_TLR)
    else $error("user pins released before tap reset");
  chk_no_cclk: assert property (o_cfg_active |-> !o_config_clock_out) // RQ3
    else $error("config clock pulsed during load");
  chk_passive_abort: assert property (cfg_go // RQ2
    && i_passive_load_active && scheme_sel == SEL_PASSIVE
    |=> o_passive_abort || !i_passive_load_active
        || scheme_sel != SEL_PASSIVE)
    else $error("passive load not aborted");
  chk_cfg_start: assert property (cfg_go |=> o_cfg_active) // RQ1
    else $error("configuration did not start at once");
  chk_tdi_sample: assert property (tck_rise && st_ff == JCP_SH_DR // RQ4
    |=> byp_ff == $past(tdi))
    else $error("tdi not sampled on rising edge");
endmodule

// ### src/jcp_pkg.sv
// Overview of operation
// RQ1: boundary-scan config has top priority and starts without waiting.
// RQ2: starting boundary-scan config aborts a passive serial load underway.
// RQ3: active serial mode gives no config clock pulse during scan config.
// RQ4: test data in is sampled on each rising test clock edge.
// RQ5: test data out changes on each falling test clock edge.
// RQ6: test data out is high impedance whenever nothing is shifted out.
// RQ7: test mode select acts and the tap state moves only on rising tck.
// RQ8: the host sets test mode select up before the rising edge using it.
// RQ9: all user pins are high impedance for the whole boundary-scan config.
// RQ10: tap states, instruction and data shifts follow the standard order.
package jcp_pkg;
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_RESET    = 4'h1;  // idcode-like default
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CONFIG   = 4'h2;  // boundary-scan configuration
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;  // fixed 01 capture pattern
  localparam int          DATA_W      = 8;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [1:0]  SEL_ACTIVE  = 2'h1;  // active_serial_scheme code
  localparam logic [1:0]  SEL_PASSIVE = 2'h2;  // passive_serial_scheme code
  localparam int          CCLK_DIV    = 2;     // config clock half period
  typedef enum logic [3:0] {
    JCP_TLR, JCP_RTI, JCP_SEL_DR, JCP_CAP_DR, JCP_SH_DR, JCP_EX1_DR,
    JCP_PA_DR, JCP_EX2_DR, JCP_UPD_DR, JCP_SEL_IR, JCP_CAP_IR,
    JCP_SH_IR, JCP_EX1_IR, JCP_PA_IR, JCP_EX2_IR, JCP_UPD_IR
  } jcp_state_e;
endpackage

// ### src/jcp_fifo.sv
`timescale 1ns/1ns
module jcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_srst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap logic only works for power-of-two depths
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be power of 2");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wr_ff;
  logic [AW:0]      rd_ff;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;
  // full when pointers differ only in the wrap bit
  assign o_in_ready  = (wr_ff ^ rd_ff) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = wr_ff != rd_ff;
  assign o_out_data  = mem_ff[rd_ff[AW-1:0]];
  always_ff @(posedge i_mclk) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= i_in_data;
  end
  // pointer update; a flush drops any half-loaded data
  always_ff @(posedge i_mclk) begin
    if (i_srst || i_flush) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW+1)'(push);
      rd_ff <= rd_ff + (AW+1)'(pop);
    end
  end
endmodule

// ### verification/jcp_jtag_host.sv
`timescale 1ns/1ns
module jcp_jtag_host (
  input  wire logic i_mclk,
  input  wire logic i_stall,
  input  wire logic i_tdo,
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi
);
  import jcp_pkg::*;
  logic tdo_smp;
  // idle levels: tck parked low, tms and tdi at their pull-up level
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  // one 320 ns tck period; tdo taken late in the high phase
  task automatic tbit(input logic tms, input logic tdi);
    int n;
    n = 0;
    @(posedge i_mclk);
    while (i_stall === 1'b1 && n < 400) begin
      @(posedge i_mclk);
      n++;
    end
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (3) @(posedge i_mclk);
    o_tck <= 1'b1;
    repeat (2) @(posedge i_mclk);
    // lines move after the rise, as a careless real host may do
    o_tms <= ~tms;
    o_tdi <= ~tdi;
    repeat (2) @(posedge i_mclk);
    tdo_smp = i_tdo;
    o_tck <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // walks of the tap graph, all ending in run-test-idle or exit-dr
  task automatic tap_reset();
    repeat (5) tbit(1'b1, 1'b1);
    tbit(1'b0, 1'b1);
  endtask
  task automatic upd_idle();
    tbit(1'b1, 1'b1);
    tbit(1'b0, 1'b1);
  endtask
  task automatic load_ir(input logic [3:0] ir, output logic [3:0] cap);
    for (int i = 0; i < 4; i++) tbit(i < 2, 1'b1);
    for (int i = 0; i < IR_W; i++) begin
      tbit(i == IR_W - 1, ir[i]);
      cap[i] = tdo_smp;
    end
    upd_idle();
  endtask
  // words go lsb first; leaves the tap in exit-dr
  task automatic shift_dr(input int cnt, input logic [7:0] base);
    logic [7:0] w;
    for (int i = 0; i < 3; i++) tbit(i == 0, 1'b1);
    for (int k = 0; k < cnt; k++) begin
      w = base + 8'(k);
      for (int b = 0; b < DATA_W; b++) tbit(k == cnt - 1 && b == 7, w[b]);
    end
  endtask
endmodule

// ### verification/tb_jcp_top.sv
`timescale 1ns/1ns
module tb_jcp_top;
  import jcp_pkg::*;
  logic       mclk, srst, tck, tms, tdi, tdo, tdo_oe, tdo_pin;
  logic [1:0] sel;
  logic       passive_load, passive_abort, active_req, cclk, hiz, active;
  logic       valid, ready, stall;
  logic [7:0] data;
  logic [3:0] cap;
  int         fails, checked, cyc, n;
  // tdo pin floats when the device lets go of it
  assign tdo_pin = tdo_oe ? tdo : 1'bz;
  jcp_top #(.DW(DATA_W)) i_jcp_top (
    .i_mclk(mclk), .i_srst(srst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_config_scheme_select(sel),
    .i_passive_load_active(passive_load), .o_passive_abort(passive_abort),
    .i_active_clock_req(active_req), .o_config_clock_out(cclk),
    .o_user_io_hiz(hiz), .o_cfg_active(active), .o_cfg_valid(valid),
    .i_cfg_ready(ready), .o_cfg_data(data), .o_stall(stall));
  jcp_jtag_host i_jcp_jtag_host (
    .i_mclk(mclk), .i_stall(stall), .i_tdo(tdo_pin),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the ~1500 cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic count_cclk(output int cnt);
    logic last;
    cnt = 0;
    @(negedge mclk) last = cclk;
    repeat (32) begin
      @(negedge mclk);
      if (cclk !== last) cnt++;
      last = cclk;
    end
  endtask
  // scheme pins pass two sync stages before the divider sees them
  task automatic t_active_clock();
    @(posedge mclk);
    sel <= SEL_ACTIVE;
    active_req <= 1'b1;
    repeat (3) @(posedge mclk);
    count_cclk(n);
    cmp(8'(n), 8'(32 / CCLK_DIV));
    i_jcp_jtag_host.tap_reset();
    i_jcp_jtag_host.load_ir(IR_CONFIG, cap);
    cmp({4'h0, cap}, {4'h0, IR_CAPTURE});
    repeat (3) @(negedge mclk);
    cmp({7'h0, active}, 8'h01);
    cmp({7'h0, hiz}, 8'h01);
    cmp({7'h0, tdo_pin}, {7'h0, 1'bz});
    count_cclk(n);
    cmp(8'(n), 8'h00);
  endtask
  // fill exactly to full with the sink stalled, then drain in order
  task automatic t_fifo();
    i_jcp_jtag_host.shift_dr(FIFO_DEPTH, 8'h30);
    repeat (8) @(negedge mclk);
    cmp({7'h0, stall}, 8'h01);
    cmp({7'h0, hiz}, 8'h01);
    @(posedge mclk) ready <= 1'b1;
    n = 0;
    for (int t = 0; t < 200 && n < FIFO_DEPTH; t++) begin
      @(negedge mclk);
      if (valid === 1'b1) begin
        cmp(data, 8'h30 + 8'(n));
        n++;
      end
    end
    cmp(8'(n), 8'(FIFO_DEPTH));
    @(negedge mclk);
    cmp({6'h0, valid, stall}, 8'h00);
    i_jcp_jtag_host.upd_idle();
  endtask
  // bypass must not start a load; config aborts the passive one
  task automatic t_passive_abort();
    i_jcp_jtag_host.tap_reset();
    @(posedge mclk);
    sel <= SEL_PASSIVE;
    passive_load <= 1'b1;
    i_jcp_jtag_host.load_ir(IR_BYPASS, cap);
    repeat (3) @(negedge mclk);
    cmp({6'h0, active, passive_abort}, 8'h00);
    i_jcp_jtag_host.load_ir(IR_CONFIG, cap);
    repeat (3) @(negedge mclk);
    cmp({6'h0, active, passive_abort}, 8'h03);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {fails, checked} = '0;
    {srst, sel, passive_load, active_req, ready} = 6'h20;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(negedge mclk);
    cmp({5'h0, tdo_oe, active, hiz}, 8'h00);
    t_active_clock();
    t_fifo();
    t_passive_abort();
    test_done();
  end
endmodule
